// ### design/irq_ctrl_pkg.sv
// Package with register map, field positions and vectors of the interrupt control.
`default_nettype none
package irq_ctrl_pkg;
  // ----------------------------------------------------------------
  // Register byte addresses
  // ----------------------------------------------------------------
  localparam logic [7:0] ADDR_CTRL_PRIMARY = 8'h00;
  localparam logic [7:0] ADDR_CTRL_SECONDARY = 8'h04;
  localparam logic [7:0] ADDR_CONFIG = 8'h08;
  localparam logic [7:0] ADDR_STATUS = 8'h0C;

  // ----------------------------------------------------------------
  // Field positions of irq_control_primary
  // ----------------------------------------------------------------
  localparam int PRI_MASTER_EN = 0;
  localparam int PRI_EXT_EN = 1;
  localparam int PRI_T0_EN = 2;
  localparam int PRI_T1_EN = 3;
  localparam int PRI_EXT_FLAG = 4;
  localparam int PRI_T0_FLAG = 5;
  localparam int PRI_T1_FLAG = 6;

  // ----------------------------------------------------------------
  // Field positions of irq_control_secondary
  // ----------------------------------------------------------------
  localparam int SEC_T2_EN = 0;
  localparam int SEC_T3_EN = 1;
  localparam int SEC_AD_EN = 2;
  localparam int SEC_T2_FLAG = 4;
  localparam int SEC_T3_FLAG = 5;
  localparam int SEC_AD_FLAG = 6;

  // Writable bits; the rest read as zero.
  localparam logic [7:0] PRI_WR_MASK = 8'h7F;
  localparam logic [7:0] SEC_WR_MASK = 8'h77;
  localparam logic [7:0] CTRL_RESET = 8'h00;

  // Config and status fields.
  localparam int CFG_BOTH_EDGES = 0;
  localparam int STAT_VEC_LSB = 0;
  localparam int STAT_DEPTH_LSB = 16;
  localparam int STAT_WAKE = 24;
  localparam int STAT_STACK_FULL = 25;

  // ----------------------------------------------------------------
  // Sources in priority order, highest first
  // ----------------------------------------------------------------
  localparam int NUM_SRC = 6;
  localparam int SRC_EXT = 0;
  localparam int SRC_T0 = 1;
  localparam int SRC_T1 = 2;
  localparam int SRC_T2 = 3;
  localparam int SRC_T3 = 4;
  localparam int SRC_AD = 5;

  localparam int PC_W = 13;
  localparam logic [PC_W-1:0] VEC_EXT = 13'h0004;
  localparam logic [PC_W-1:0] VEC_T0 = 13'h0008;
  localparam logic [PC_W-1:0] VEC_T1 = 13'h000C;
  localparam logic [PC_W-1:0] VEC_T2 = 13'h0010;
  localparam logic [PC_W-1:0] VEC_T3 = 13'h0014;
  localparam logic [PC_W-1:0] VEC_AD = 13'h0018;
  localparam logic [PC_W-1:0] VEC_NONE = 13'h0000;

  localparam int DEPTH_W = 4;
  localparam logic [DEPTH_W-1:0] DEPTH_MAX = 4'hF;
  localparam logic [DEPTH_W-1:0] DEPTH_ONE = 4'h1;
endpackage : irq_ctrl_pkg
`default_nettype wire

// ### design/vectored_interrupt_control.sv
// Interrupt request latching, priority selection and vectoring with APB access.
//
// How it works
// - Enabled source event sets its request flag.
// - Master enable low blocks all servicing.
// - Call strobe: sequencer pushes next PC, jumps.
// - Return strobe pops; nesting depth drops.
// - Entering service clears master enable.
// - Blocked requests stay latched for later.
// - Full stack blocks acknowledgement.
// - Requests serviced at next second-phase pulse.
// - Fixed priority: pin, timers 0-3, converter.
// - Pin interrupt vectors to 04H.
// - Timers vector to 08H, 0CH, 10H, 14H.
// - Converter vectors 18H; software flag set requests.
// - Pin enable bit 1, flag bit 4; converter flag bit 6.
// - Each timer has enable and flag bits.
// - Pin trigger: falling only, or both edges.
// - Serviced source flag cleared on entry.
// - Flags persist until serviced or cleared.
// - Any set flag raises wake request.
// - Timer overflow pulse marks wrap past FFH.
//
// Decided for this implementation: register access over APB and the placing of the registers.
`default_nettype none
module vectored_interrupt_control (
  input wire logic CLK_SYS,
  input wire logic RST_N,
  input wire logic PSEL,
  input wire logic PENABLE,
  input wire logic PWRITE,
  input wire logic [7:0] PADDR,
  input wire logic [31:0] PWDATA,
  output logic [31:0] PRDATA,
  output logic PREADY,
  output logic PSLVERR,
  input wire logic EXT_PIN,
  input wire logic [3:0] TIMER_OVERFLOW,
  input wire logic CONVERSION_DONE,
  input wire logic SECOND_MACHINE_PHASE,
  input wire logic STACK_FULL,
  input wire logic RETURN_DONE,
  output logic IRQ_CALL,
  output logic [12:0] IRQ_VECTOR,
  output logic WAKE
);

  // ----------------------------------------------------------------
  // Register map
  // ----------------------------------------------------------------
  // Offset 0x00 is the primary control register.
  // Its bit 0 is the master enable, bits 1 to 3 enable the pin,
  // timer zero and timer one, and bits 4 to 6 are their flags.
  // Offset 0x04 is the secondary control register.
  // Its bits 0 to 2 enable timer two, timer three and the
  // converter, and bits 4 to 6 are their flags.
  // Bit 7 of both control registers and bit 3 of the secondary
  // register read as zero and ignore writes.
  // Software may set any flag directly, which raises a request
  // exactly as the hardware event would.
  // Offset 0x08 holds the trigger choice of the pin in bit 0.
  // A one there makes both edges active, a zero only falling ones.
  // Offset 0x0C is a read-only status word.
  // It shows the last vector, the service depth, the wake level and
  // the stack-full input as the sequencer presents it.
  // Any other offset answers with the error flag and reads zero.
  // The service depth counts calls minus returns and saturates, so
  // it is a debugging aid and not a stack model.

  // ----------------------------------------------------------------
  // State
  // ----------------------------------------------------------------
  typedef struct packed {
    // Primary control register, master enable included.
    logic [7:0] ctl_pri;
    // Secondary control register.
    logic [7:0] ctl_sec;
    // Pin trigger choice: one for both edges.
    logic both_edges;
    // Two synchroniser stages and the previous pin level.
    logic pin_s1;
    logic pin_s2;
    logic pin_prev;
    // One-cycle call strobe to the sequencer.
    logic call;
    // Vector of the last accepted source.
    logic [irq_ctrl_pkg::PC_W-1:0] vector;
    // Calls not yet matched by a return.
    logic [irq_ctrl_pkg::DEPTH_W-1:0] depth;
    // High while any request flag is set.
    logic wake;
    // Registered bus answer.
    logic pready;
    logic [31:0] prdata;
    logic pslverr;
  } state_t;

  localparam state_t STATE_RESET = '{
    ctl_pri: irq_ctrl_pkg::CTRL_RESET,
    ctl_sec: irq_ctrl_pkg::CTRL_RESET,
    both_edges: 1'b0,
    pin_s1: 1'b1,
    pin_s2: 1'b1,
    pin_prev: 1'b1,
    call: 1'b0,
    vector: irq_ctrl_pkg::VEC_NONE,
    depth: '0,
    wake: 1'b0,
    pready: 1'b0,
    prdata: 32'h00000000,
    pslverr: 1'b0
  };

  state_t state_ff;
  state_t nxt_state;

  // ----------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------
  function automatic logic [irq_ctrl_pkg::PC_W-1:0] vector_of(
    input logic [2:0] idx
  );
    logic [irq_ctrl_pkg::PC_W-1:0] v;
    v = irq_ctrl_pkg::VEC_NONE;
    unique case (idx)
      3'h0: v = irq_ctrl_pkg::VEC_EXT;
      3'h1: v = irq_ctrl_pkg::VEC_T0;
      3'h2: v = irq_ctrl_pkg::VEC_T1;
      3'h3: v = irq_ctrl_pkg::VEC_T2;
      3'h4: v = irq_ctrl_pkg::VEC_T3;
      3'h5: v = irq_ctrl_pkg::VEC_AD;
      default: v = irq_ctrl_pkg::VEC_NONE;
    endcase
    return v;
  endfunction : vector_of

  // Lowest index wins, which is the highest priority.
  function automatic logic [2:0] pick_winner(
    input logic [irq_ctrl_pkg::NUM_SRC-1:0] pend
  );
    logic [2:0] w;
    w = 3'h0;
    for (int i = irq_ctrl_pkg::NUM_SRC - 1; i >= 0; i--) begin
      if (pend[i]) begin
        w = 3'(i);
      end
    end
    return w;
  endfunction : pick_winner

  // Collects the enable bits of all sources in priority order.
  function automatic logic [irq_ctrl_pkg::NUM_SRC-1:0] enables_of(
    input logic [7:0] pri,
    input logic [7:0] sec
  );
    logic [irq_ctrl_pkg::NUM_SRC-1:0] e;
    e = '0;
    e[irq_ctrl_pkg::SRC_EXT] = pri[irq_ctrl_pkg::PRI_EXT_EN];
    e[irq_ctrl_pkg::SRC_T0] = pri[irq_ctrl_pkg::PRI_T0_EN];
    e[irq_ctrl_pkg::SRC_T1] = pri[irq_ctrl_pkg::PRI_T1_EN];
    e[irq_ctrl_pkg::SRC_T2] = sec[irq_ctrl_pkg::SEC_T2_EN];
    e[irq_ctrl_pkg::SRC_T3] = sec[irq_ctrl_pkg::SEC_T3_EN];
    e[irq_ctrl_pkg::SRC_AD] = sec[irq_ctrl_pkg::SEC_AD_EN];
    return e;
  endfunction : enables_of

  // Collects the request flags of all sources in priority order.
  function automatic logic [irq_ctrl_pkg::NUM_SRC-1:0] flags_of(
    input logic [7:0] pri,
    input logic [7:0] sec
  );
    logic [irq_ctrl_pkg::NUM_SRC-1:0] f;
    f = '0;
    f[irq_ctrl_pkg::SRC_EXT] = pri[irq_ctrl_pkg::PRI_EXT_FLAG];
    f[irq_ctrl_pkg::SRC_T0] = pri[irq_ctrl_pkg::PRI_T0_FLAG];
    f[irq_ctrl_pkg::SRC_T1] = pri[irq_ctrl_pkg::PRI_T1_FLAG];
    f[irq_ctrl_pkg::SRC_T2] = sec[irq_ctrl_pkg::SEC_T2_FLAG];
    f[irq_ctrl_pkg::SRC_T3] = sec[irq_ctrl_pkg::SEC_T3_FLAG];
    f[irq_ctrl_pkg::SRC_AD] = sec[irq_ctrl_pkg::SEC_AD_FLAG];
    return f;
  endfunction : flags_of

  // Tells whether an offset names one of the four registers.
  function automatic logic is_mapped(
    input logic [7:0] addr
  );
    logic m;
    m = 1'b0;
    if (addr == irq_ctrl_pkg::ADDR_CTRL_PRIMARY
        || addr == irq_ctrl_pkg::ADDR_CTRL_SECONDARY
        || addr == irq_ctrl_pkg::ADDR_CONFIG
        || addr == irq_ctrl_pkg::ADDR_STATUS) begin
      m = 1'b1;
    end
    return m;
  endfunction : is_mapped

  // Builds the read word; unmapped offsets read as zero.
  function automatic logic [31:0] read_word(
    input logic [7:0] addr,
    input state_t s,
    input logic full
  );
    logic [31:0] w;
    w = 32'h00000000;
    unique case (addr)
      irq_ctrl_pkg::ADDR_CTRL_PRIMARY: begin
        w[7:0] = s.ctl_pri;
      end
      irq_ctrl_pkg::ADDR_CTRL_SECONDARY: begin
        w[7:0] = s.ctl_sec;
      end
      irq_ctrl_pkg::ADDR_CONFIG: begin
        w[irq_ctrl_pkg::CFG_BOTH_EDGES] = s.both_edges;
      end
      irq_ctrl_pkg::ADDR_STATUS: begin
        w[irq_ctrl_pkg::STAT_VEC_LSB +: irq_ctrl_pkg::PC_W] = s.vector;
        w[irq_ctrl_pkg::STAT_DEPTH_LSB +: irq_ctrl_pkg::DEPTH_W] =
          s.depth;
        w[irq_ctrl_pkg::STAT_WAKE] = s.wake;
        w[irq_ctrl_pkg::STAT_STACK_FULL] = full;
      end
      default: begin
      end
    endcase
    return w;
  endfunction : read_word

  // ----------------------------------------------------------------
  // Next state
  // ----------------------------------------------------------------
  logic [irq_ctrl_pkg::NUM_SRC-1:0] en;
  logic [irq_ctrl_pkg::NUM_SRC-1:0] flag;
  logic [irq_ctrl_pkg::NUM_SRC-1:0] cur_en;
  logic [irq_ctrl_pkg::NUM_SRC-1:0] cur_flag;
  logic [irq_ctrl_pkg::NUM_SRC-1:0] pend;
  logic [irq_ctrl_pkg::NUM_SRC-1:0] evt;
  logic ext_evt;
  logic wr_en;
  logic acc;
  logic take;
  logic [2:0] win;

  always_comb begin
    nxt_state = state_ff;
    nxt_state.call = 1'b0;

    // Pin synchroniser; only the second stage feeds the edge logic.
    // The stages reset to one, the idle level of the pin, so no
    // false edge follows reset while the pin rests high.
    // A pin that is low at release is seen as a falling edge.
    nxt_state.pin_s1 = EXT_PIN;
    nxt_state.pin_s2 = state_ff.pin_s1;
    nxt_state.pin_prev = state_ff.pin_s2;
    ext_evt = (state_ff.pin_prev & ~state_ff.pin_s2)
      | (state_ff.both_edges & ~state_ff.pin_prev & state_ff.pin_s2);

    // Register writes take effect at the completing access edge.
    wr_en = PSEL & PENABLE & state_ff.pready & PWRITE;
    if (wr_en) begin
      unique case (PADDR)
        irq_ctrl_pkg::ADDR_CTRL_PRIMARY: begin
          nxt_state.ctl_pri = PWDATA[7:0] & irq_ctrl_pkg::PRI_WR_MASK;
        end
        irq_ctrl_pkg::ADDR_CTRL_SECONDARY: begin
          nxt_state.ctl_sec = PWDATA[7:0] & irq_ctrl_pkg::SEC_WR_MASK;
        end
        irq_ctrl_pkg::ADDR_CONFIG: begin
          nxt_state.both_edges = PWDATA[irq_ctrl_pkg::CFG_BOTH_EDGES];
        end
        default: begin
        end
      endcase
    end

    // Gather enables and flags by source, priority order.
    // The current values choose the winner; the written values are
    // the base on which service clears and events are applied.
    cur_en = enables_of(state_ff.ctl_pri, state_ff.ctl_sec);
    cur_flag = flags_of(state_ff.ctl_pri, state_ff.ctl_sec);
    en = enables_of(nxt_state.ctl_pri, nxt_state.ctl_sec);
    flag = flags_of(nxt_state.ctl_pri, nxt_state.ctl_sec);

    // Flags stay set whatever the enables do.
    pend = cur_flag & cur_en;
    take = SECOND_MACHINE_PHASE
      & state_ff.ctl_pri[irq_ctrl_pkg::PRI_MASTER_EN]
      & ~STACK_FULL
      & (|pend);
    win = pick_winner(pend);
    // The call strobe, the vector, the flag clear and the master
    // clear all land on the same edge, so the sequencer never sees
    // a call without its vector.
    // A software write of the master enable in that same cycle
    // loses to the hardware clear, which keeps nesting off.
    if (take) begin
      nxt_state.call = 1'b1;
      nxt_state.vector = vector_of(win);
      flag[win] = 1'b0;
      nxt_state.ctl_pri[irq_ctrl_pkg::PRI_MASTER_EN] = 1'b0;
    end

    // Events are applied last so a set beats any clear in the same cycle.
    evt = {CONVERSION_DONE, TIMER_OVERFLOW, ext_evt};
    flag = flag | (evt & en);

    nxt_state.ctl_pri[irq_ctrl_pkg::PRI_EXT_FLAG] = flag[irq_ctrl_pkg::SRC_EXT];
    nxt_state.ctl_pri[irq_ctrl_pkg::PRI_T0_FLAG] = flag[irq_ctrl_pkg::SRC_T0];
    nxt_state.ctl_pri[irq_ctrl_pkg::PRI_T1_FLAG] = flag[irq_ctrl_pkg::SRC_T1];
    nxt_state.ctl_sec[irq_ctrl_pkg::SEC_T2_FLAG] = flag[irq_ctrl_pkg::SRC_T2];
    nxt_state.ctl_sec[irq_ctrl_pkg::SEC_T3_FLAG] = flag[irq_ctrl_pkg::SRC_T3];
    nxt_state.ctl_sec[irq_ctrl_pkg::SEC_AD_FLAG] = flag[irq_ctrl_pkg::SRC_AD];

    // Service nesting depth, saturating at both ends.
    if (take && !(RETURN_DONE && state_ff.depth != '0)) begin
      if (state_ff.depth != irq_ctrl_pkg::DEPTH_MAX) begin
        nxt_state.depth = state_ff.depth + irq_ctrl_pkg::DEPTH_ONE;
      end
    end else if (!take && RETURN_DONE && state_ff.depth != '0) begin
      nxt_state.depth = state_ff.depth - irq_ctrl_pkg::DEPTH_ONE;
    end

    nxt_state.wake = |flag;

    // ----------------------------------------------------------------
    // APB: one wait state, then a one-cycle ready with data.
    // ----------------------------------------------------------------
    // The answer is registered, so every transfer has exactly one
    // wait state; the read word is taken in the access cycle and the
    // write lands at the edge that completes the transfer.
    // Ready drops after one cycle, so a master that holds its
    // request a cycle too long starts a second access.
    acc = PSEL & PENABLE & ~state_ff.pready;
    nxt_state.pready = acc;
    nxt_state.prdata = 32'h00000000;
    nxt_state.pslverr = 1'b0;
    if (acc) begin
      nxt_state.prdata = read_word(PADDR, state_ff, STACK_FULL);
      nxt_state.pslverr = ~is_mapped(PADDR);
    end
  end

  // ----------------------------------------------------------------
  // Registers
  // ----------------------------------------------------------------
  always_ff @(posedge CLK_SYS) begin
    if (!RST_N) begin
      state_ff <= STATE_RESET;
    end else begin
      state_ff <= nxt_state;
    end
  end

  assign PRDATA = state_ff.prdata;
  assign PREADY = state_ff.pready;
  assign PSLVERR = state_ff.pslverr;
  assign IRQ_CALL = state_ff.call;
  assign IRQ_VECTOR = state_ff.vector;
  assign WAKE = state_ff.wake;

endmodule : vectored_interrupt_control
`default_nettype wire

// ### dv/irq_ctrl_sva.sv
// Checker of the interrupt control port behaviour.
`default_nettype none
module irq_ctrl_sva (
  input wire logic CLK_SYS,
  input wire logic RST_N,
  input wire logic PSEL,
  input wire logic PENABLE,
  input wire logic PWRITE,
  input wire logic PREADY,
  input wire logic PSLVERR,
  input wire logic SECOND_MACHINE_PHASE,
  input wire logic STACK_FULL,
  input wire logic IRQ_CALL,
  input wire logic [12:0] IRQ_VECTOR,
  input wire logic WAKE
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking cb @(posedge CLK_SYS);
  endclocking
  default disable iff (!RST_N);
  property p_call_cause;
    IRQ_CALL |-> $past(SECOND_MACHINE_PHASE) && !$past(STACK_FULL)
      && $past(WAKE);
  endproperty
  a_call_cause: assert property (p_call_cause) else $error("call cause");
  property p_call_single;
    IRQ_CALL |=> !IRQ_CALL;
  endproperty
  a_call_single: assert property (p_call_single) else $error("call twice");
  property p_vec_table;
    IRQ_CALL |-> IRQ_VECTOR inside {13'h4, 13'h8, 13'hC, 13'h10, 13'h14, 13'h18};
  endproperty
  a_vec_table: assert property (p_vec_table) else $error("bad vector");
  property p_vec_hold;
    !IRQ_CALL |-> $stable(IRQ_VECTOR);
  endproperty
  a_vec_hold: assert property (p_vec_hold) else $error("vector moved");
  property p_flag_hold;
    WAKE && !(PREADY && PWRITE) |=> WAKE || IRQ_CALL;
  endproperty
  a_flag_hold: assert property (p_flag_hold) else $error("flag lost");
  property p_ready_wait;
    PSEL && PENABLE && !PREADY |=> PREADY;
  endproperty
  a_ready_wait: assert property (p_ready_wait) else $error("no ready");
  property p_ready_pulse;
    PREADY |=> !PREADY;
  endproperty
  a_ready_pulse: assert property (p_ready_pulse) else $error("long ready");
  property p_err_ready;
    PSLVERR |-> PREADY && PSEL && PENABLE;
  endproperty
  a_err_ready: assert property (p_err_ready) else $error("stray error");
  c_call: cover property (IRQ_CALL);
  c_err: cover property (PSLVERR);
  c_pin_vec: cover property (IRQ_CALL && IRQ_VECTOR == 13'h4);
endmodule : irq_ctrl_sva
bind vectored_interrupt_control irq_ctrl_sva i_irq_ctrl_sva (.CLK_SYS,
  .RST_N, .PSEL, .PENABLE, .PWRITE, .PREADY, .PSLVERR,
  .SECOND_MACHINE_PHASE, .STACK_FULL, .IRQ_CALL, .IRQ_VECTOR, .WAKE);
`default_nettype wire

// ### dv/core_sequencer_model.sv
// Model of the core sequencer: phase pulses, stack state and returns.
`default_nettype none
module core_sequencer_model (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic irq_call,
  input wire logic full_req,
  output logic phase,
  output logic stack_full,
  output logic ret_done
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [1:0] tick;
  logic [1:0] ret_cnt;
  always @(posedge clk) begin
    if (!rst_n) begin
      tick <= 2'h0;
      ret_cnt <= 2'h0;
      phase <= 1'b0;
      stack_full <= 1'b0;
      ret_done <= 1'b0;
    end else begin
      tick <= tick + 2'h1;
      phase <= (tick == 2'h3);
      stack_full <= full_req;
      ret_done <= (ret_cnt == 2'h1);
      // Only the program counter is pushed and the routine makes no
      // subroutine call before it returns.
      if (irq_call) begin
        ret_cnt <= 2'h3;
      end else if (ret_cnt != 2'h0) begin
        ret_cnt <= ret_cnt - 2'h1;
      end
    end
  end
endmodule : core_sequencer_model
`default_nettype wire

// ### dv/vectored_interrupt_control_tb.sv
// Self-checking testbench of the vectored interrupt control.
`default_nettype none
module vectored_interrupt_control_tb;
  timeunit 1ns;
  timeprecision 1ps;
  localparam logic [7:0] pri_a = irq_ctrl_pkg::ADDR_CTRL_PRIMARY;
  localparam logic [7:0] sec_a = irq_ctrl_pkg::ADDR_CTRL_SECONDARY;
  logic clk = 1'b0;
  logic rst_n = 1'b0;
  logic psel = 1'b0;
  logic pen = 1'b0;
  logic pwr = 1'b0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0;
  logic ext_pin = 1'b1;
  logic [3:0] tov = 4'h0;
  logic conv = 1'b0;
  logic full_req = 1'b0;
  wire logic [31:0] prdata;
  wire logic pready, pslverr, phase, stack_full, ret_done, irq_call, wake;
  wire logic [12:0] irq_vector;
  int fails = 0;
  int checked = 0;
  int calls = 0;
  logic [12:0] last_vec = 13'h0;
  logic [31:0] rd;
  logic err;
  logic [5:0] pend;
  vectored_interrupt_control i_vectored_interrupt_control (.CLK_SYS(clk),
    .RST_N(rst_n), .PSEL(psel), .PENABLE(pen), .PWRITE(pwr), .PADDR(paddr),
    .PWDATA(pwdata), .PRDATA(prdata), .PREADY(pready), .PSLVERR(pslverr),
    .EXT_PIN(ext_pin), .TIMER_OVERFLOW(tov), .CONVERSION_DONE(conv),
    .SECOND_MACHINE_PHASE(phase), .STACK_FULL(stack_full),
    .RETURN_DONE(ret_done), .IRQ_CALL(irq_call), .IRQ_VECTOR(irq_vector),
    .WAKE(wake));
  core_sequencer_model i_core_sequencer_model (.clk(clk), .rst_n(rst_n),
    .irq_call(irq_call), .full_req(full_req), .phase(phase),
    .stack_full(stack_full), .ret_done(ret_done));
  initial begin
    forever #10 clk = ~clk;
  end
  always @(negedge clk) begin
    if (irq_call === 1'b1) begin
      calls++;
      last_vec = irq_vector;
    end
  end
  task automatic chk(input string what, input logic [31:0] exp,
                     input logic [31:0] got);
    checked++;
    if (got !== exp) begin
      fails++;
      $display("unexpected %s: expected %h seen %h", what, exp, got);
    end
  endtask : chk
  // Ready and data are read at the rising edge that samples them.
  task automatic apb(input logic wr, input logic [7:0] a,
                     input logic [31:0] d);
    int n;
    @(posedge clk);
    psel <= 1'b1;
    pwr <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    pen <= 1'b1;
    n = 0;
    do begin
      @(posedge clk);
      n++;
    end while (pready !== 1'b1 && n < 20);
    if (pready !== 1'b1) fails++;
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    pen <= 1'b0;
  endtask : apb
  task automatic wait_call(input logic [12:0] vec);
    int n;
    n = calls;
    repeat (40) if (calls == n) @(posedge clk);
    chk("call count", 32'(n + 1), 32'(calls));
    chk("vector", 32'(vec), 32'(last_vec));
  endtask : wait_call
  task automatic pin_move(input logic v, input logic [31:0] exp);
    @(posedge clk);
    ext_pin <= v;
    repeat (6) @(posedge clk);
    apb(1'b0, pri_a, 32'h0);
    chk("pin flag", exp, rd);
    apb(1'b1, pri_a, 32'h02);
  endtask : pin_move
  // ----------------------------------------------------------------
  // Scenarios
  // ----------------------------------------------------------------
  task automatic t_reset;
    apb(1'b0, pri_a, 32'h0);
    chk("primary", 32'h0, rd);
    apb(1'b0, sec_a, 32'h0);
    chk("secondary", 32'h0, rd);
    apb(1'b0, 8'h10, 32'h0);
    chk("unmapped error", 32'h1, 32'(err));
    chk("unmapped data", 32'h0, rd);
  endtask : t_reset
  task automatic t_priority;
    int n;
    pend = 6'h3F;
    apb(1'b1, sec_a, 32'h77);
    apb(1'b1, pri_a, 32'h7E);
    n = calls;
    repeat (12) @(posedge clk);
    chk("blocked calls", 32'(n), 32'(calls));
    apb(1'b1, pri_a, 32'h7F);
    for (int i = 0; i < 6; i++) begin
      wait_call(13'(4 * (i + 1)));
      pend[i] = 1'b0;
      apb(1'b0, pri_a, 32'h0);
      chk("primary", {25'h0, pend[2:0], 4'hE}, rd);
      apb(1'b0, sec_a, 32'h0);
      chk("secondary", {25'h0, pend[5:3], 4'h7}, rd);
      if (i < 5) apb(1'b1, pri_a, {25'h0, pend[2:0], 4'hF});
    end
  endtask : t_priority
  task automatic t_events;
    apb(1'b1, sec_a, 32'h01);
    @(posedge clk);
    tov <= 4'hC;
    @(posedge clk);
    tov <= 4'h0;
    apb(1'b0, sec_a, 32'h0);
    chk("timer flags", 32'h11, rd);
    apb(1'b1, sec_a, 32'h14);
    @(posedge clk);
    conv <= 1'b1;
    @(posedge clk);
    conv <= 1'b0;
    apb(1'b0, sec_a, 32'h0);
    chk("converter flag", 32'h54, rd);
    apb(1'b1, pri_a, 32'h02);
    pin_move(1'b0, 32'h12);
    pin_move(1'b1, 32'h02);
    apb(1'b1, irq_ctrl_pkg::ADDR_CONFIG, 32'h01);
    pin_move(1'b0, 32'h12);
    pin_move(1'b1, 32'h12);
  endtask : t_events
  task automatic t_stack;
    int n;
    @(posedge clk);
    full_req <= 1'b1;
    apb(1'b1, pri_a, 32'h25);
    n = calls;
    repeat (12) @(posedge clk);
    chk("calls while full", 32'(n), 32'(calls));
    full_req <= 1'b0;
    wait_call(13'h0008);
    repeat (8) @(posedge clk);
    apb(1'b0, irq_ctrl_pkg::ADDR_STATUS, 32'h0);
    chk("status", 32'h01000008, rd);
    chk("wake", 32'h1, 32'(wake));
  endtask : t_stack
  task automatic complete_run;
    if (fails == 0 && checked > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask : complete_run
  initial begin
    repeat (10) @(posedge clk);
    rst_n <= 1'b1;
    t_reset();
    t_priority();
    t_events();
    t_stack();
    complete_run();
  end
  initial begin
    repeat (5000) @(posedge clk);
    fails++;
    complete_run();
  end
endmodule : vectored_interrupt_control_tb
`default_nettype wire
